// File: rtl/fleo_pkg.sv
package fleo_pkg;
   // -------------------------------------------------------------
   // clock and timing
   // -------------------------------------------------------------
   localparam int unsigned CLK_MHZ = 50;
   localparam int unsigned T_RESET_LOW_NS = 500;
   localparam int unsigned T_RH_NS = 50;
   localparam int unsigned T_RPD_US = 20;
   localparam int unsigned T_READY_ALG_US = 20;
   localparam int unsigned T_BUSY_NS = 90;
   localparam int unsigned T_RSP_US = 4;
   localparam int unsigned T_RRB_US = 4;
   localparam int unsigned T_PROG_MAX_US = 100;
   localparam int unsigned T_ACC_PROG_MAX_US = 60;
   localparam int unsigned T_SECT_MAX_MS = 2000;
   localparam int unsigned T_CHIP_MAX_MS = 113600;
   // least times round up, longest round down
   localparam int unsigned RPD_CYC = T_RPD_US * CLK_MHZ;
   localparam int unsigned RH_CYC = (T_RH_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned READY_CYC = T_READY_ALG_US * CLK_MHZ;
   localparam int unsigned BUSY_CYC = (T_BUSY_NS * CLK_MHZ) / 1000;
   localparam int unsigned RSP_CYC = T_RSP_US * CLK_MHZ;
   localparam int unsigned RRB_CYC = T_RRB_US * CLK_MHZ;
   localparam int unsigned PROG_CYC = T_PROG_MAX_US * CLK_MHZ;
   localparam int unsigned ACC_CYC = T_ACC_PROG_MAX_US * CLK_MHZ;
   localparam longint unsigned SECT_CYC =
      longint'(T_SECT_MAX_MS) * 1000 * CLK_MHZ;
   localparam longint unsigned CHIP_CYC =
      longint'(T_CHIP_MAX_MS) * 1000 * CLK_MHZ;
   localparam int CNT_W = 40;
   // -------------------------------------------------------------
   // register map
   // -------------------------------------------------------------
   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_ADDR = 12'h004;
   localparam logic [11:0] REG_DATA = 12'h008;
   localparam logic [11:0] REG_STAT = 12'h00c;
   localparam logic [11:0] REG_RDAT = 12'h010;
   localparam int ADDR_W = 22;
   localparam int DATA_W = 16;
   // ctrl command codes, bits 2:0
   localparam logic [2:0] CMD_NONE = 3'h0;
   localparam logic [2:0] CMD_READ = 3'h1;
   localparam logic [2:0] CMD_WRITE = 3'h2;
   localparam logic [2:0] CMD_RESET = 3'h3;
   localparam logic [2:0] CMD_WAIT = 3'h4;
   localparam logic [2:0] CMD_PROT = 3'h5;
   localparam logic [2:0] CMD_UNPROT = 3'h6;
   // ctrl bits
   localparam int CTRL_OP_LSB = 4;
   localparam int CTRL_ACC_BIT = 6;
   localparam int CTRL_HV_BIT = 7;
   localparam int CTRL_OE_TOG_BIT = 8;
   // op kinds for completion limits
   localparam logic [1:0] OP_PROG = 2'h0;
   localparam logic [1:0] OP_SECT = 2'h1;
   localparam logic [1:0] OP_CHIP = 2'h2;
   // status bits
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_FAIL = 2;
   localparam int ST_TMO = 3;
   localparam int ST_RDY = 4;
   // address bits for protect selection, bus strobe cycles, status data bits
   localparam int A_SIX = 6;
   localparam int A_ONE = 1;
   localparam int A_ZERO = 0;
   localparam int BUS_PULSE = 4;
   localparam int POLL_BIT = 7;
   localparam int TOG_BIT = 6;
   localparam int TMO_BIT = 5;
endpackage : fleo_pkg

// File: rtl/fleo_host.sv
// Contract
// - wait 50ns after reset release before read
// - protect: addr six low, one high, zero low
// - unprotect: addr six high, one high, zero low
// - status reads cycle output or chip enable
// - elevated reset 4us before first write
// - elevated reset held 4us after ready
// - status reads target the busy bank; the host polls at whatever address REG_ADDR holds
`timescale 1ns/1ns
module fleo_host
   import fleo_pkg::*;
(
   // apb slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // flash pins
   output logic [ADDR_W-1:0] flash_addr,
   input wire logic [DATA_W-1:0] flash_dq_in,
   output logic [DATA_W-1:0] flash_dq_out,
   output logic flash_dq_oe,
   output logic flash_ce_n,
   output logic flash_oe_n,
   output logic flash_we_n,
   output logic flash_reset_n,
   output logic flash_reset_hv,
   output logic protect_accel_input,
   input wire logic ready_busy_out_n
);
   typedef enum {
      S_IDLE, S_RD, S_WR, S_RST, S_RH, S_WAIT, S_HV_SET, S_HV_HOLD
   } fleo_state_e;
   typedef struct packed {
      fleo_state_e st;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] lim;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdat;
      logic [DATA_W-1:0] rdat;
      logic [DATA_W-1:0] prev;
      logic [DATA_W-1:0] dq1;
      logic [DATA_W-1:0] dq2;
      logic first;
      logic use_oe;
      logic acc;
      logic done;
      logic fail;
      logic tmo;
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic dq_oe;
      logic rst_n;
      logic hv;
      logic rby1;
      logic rby2;
   } fleo_s;
   fleo_s s_reg, s_next;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   function automatic logic [CNT_W-1:0] op_limit(input logic [1:0] k,
                                                  input logic a);
      case (k)
         OP_PROG: op_limit = CNT_W'(a ? ACC_CYC : PROG_CYC);
         OP_SECT: op_limit = CNT_W'(SECT_CYC);
         default: op_limit = CNT_W'(CHIP_CYC);
      endcase
   endfunction : op_limit
   function automatic logic [ADDR_W-1:0] prot_addr(
      input logic [ADDR_W-1:0] a, input logic un);
      prot_addr = a;
      prot_addr[A_SIX] = un;
      prot_addr[A_ONE] = 1'b1;
      prot_addr[A_ZERO] = 1'b0;
   endfunction : prot_addr
   wire logic wr_ctrl = psel && penable && pwrite && paddr == REG_CTRL;
   wire logic [2:0] cmd = pwdata[2:0];
   // -------------------------------------------------------------
   // next state
   // -------------------------------------------------------------
   always_comb
   begin
      s_next = s_reg;
      s_next.rby1 = ready_busy_out_n;
      s_next.rby2 = s_reg.rby1;
      s_next.dq1 = flash_dq_in;
      s_next.dq2 = s_reg.dq1;
      s_next.cnt = s_reg.cnt + CNT_W'(1);
      if (psel && penable && pwrite && paddr == REG_ADDR)
         s_next.addr = pwdata[ADDR_W-1:0];
      if (psel && penable && pwrite && paddr == REG_DATA)
         s_next.wdat = pwdata[DATA_W-1:0];
      case (s_reg.st)
         S_IDLE:
         begin
            s_next.cnt = '0;
            if (wr_ctrl)
            begin
               s_next.acc = pwdata[CTRL_ACC_BIT];
               s_next.use_oe = pwdata[CTRL_OE_TOG_BIT];
               s_next.done = 1'b0;
               case (cmd)
                  CMD_READ:
                  begin
                     s_next.st = S_RD;
                     s_next.ce_n = 1'b0;
                     s_next.oe_n = 1'b0;
                  end
                  CMD_WRITE, CMD_PROT, CMD_UNPROT:
                  begin
                     s_next.st = S_WR;
                     if (cmd != CMD_WRITE)
                        s_next.addr = prot_addr(s_reg.addr,
                                                cmd == CMD_UNPROT);
                     s_next.ce_n = 1'b0;
                     s_next.we_n = 1'b0;
                     s_next.dq_oe = 1'b1;
                  end
                  CMD_RESET:
                  begin
                     s_next.st = S_RST;
                     s_next.rst_n = 1'b0;
                     s_next.lim = pwdata[CTRL_HV_BIT] ? CNT_W'(RPD_CYC)
                                : CNT_W'(READY_CYC);
                  end
                  CMD_WAIT:
                  begin
                     s_next.st = S_WAIT;
                     s_next.lim = op_limit(pwdata[CTRL_OP_LSB+:2],
                                           pwdata[CTRL_ACC_BIT]);
                     s_next.fail = 1'b0;
                     s_next.tmo = 1'b0;
                     s_next.first = 1'b1;
                  end
                  default:
                     if (pwdata[CTRL_HV_BIT] != s_reg.hv)
                     begin
                        s_next.st = pwdata[CTRL_HV_BIT] ? S_HV_SET
                                                        : S_HV_HOLD;
                        s_next.hv = 1'b1;
                     end
               endcase
            end
         end
         S_RD, S_WR:
            if (s_reg.cnt == CNT_W'(BUS_PULSE - 1))
            begin
               if (s_reg.st == S_RD)
                  s_next.rdat = s_reg.dq2;
               s_next.ce_n = 1'b1;
               s_next.oe_n = 1'b1;
               s_next.we_n = 1'b1;
               s_next.dq_oe = 1'b0;
               s_next.st = S_IDLE;
            end
         S_RST:
            if (s_reg.cnt >= s_reg.lim - CNT_W'(1))
            begin
               s_next.rst_n = 1'b1;
               s_next.cnt = '0;
               s_next.st = S_RH;
            end
         S_RH:
            if (s_reg.cnt >= CNT_W'(RH_CYC))
               s_next.st = S_IDLE;
         S_WAIT:
         begin
            // poll by toggling a strobe, compare successive reads
            s_next.ce_n = s_reg.use_oe ? 1'b0 : s_reg.cnt[2];
            s_next.oe_n = s_reg.cnt[2];
            if (s_reg.cnt[2:0] == 3'h3)
            begin
               s_next.prev = s_reg.dq2;
               s_next.first = 1'b0;
               if (s_reg.dq2[TMO_BIT])
                  s_next.tmo = 1'b1;
               if (!s_reg.first && s_reg.cnt > CNT_W'(BUSY_CYC) &&
                   s_reg.dq2[TOG_BIT] == s_reg.prev[TOG_BIT] &&
                   s_reg.rby2)
               begin
                  s_next.done = 1'b1;
                  s_next.ce_n = 1'b1;
                  s_next.oe_n = 1'b1;
                  s_next.st = S_IDLE;
               end
            end
            if (s_reg.cnt >= s_reg.lim)
            begin
               s_next.fail = 1'b1;
               s_next.ce_n = 1'b1;
               s_next.oe_n = 1'b1;
               s_next.rst_n = 1'b0;
               s_next.cnt = '0;
               s_next.lim = CNT_W'(READY_CYC);
               s_next.st = S_RST;
            end
         end
         S_HV_SET:
            if (s_reg.cnt >= CNT_W'(RSP_CYC))
               s_next.st = S_IDLE;
         S_HV_HOLD:
            if (!s_reg.rby2)
               s_next.cnt = '0;
            else if (s_reg.cnt >= CNT_W'(RRB_CYC))
            begin
               s_next.hv = 1'b0;
               s_next.st = S_IDLE;
            end
         default: s_next.st = S_IDLE;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_reg <= '0;
         s_reg.ce_n <= 1'b1;
         s_reg.oe_n <= 1'b1;
         s_reg.we_n <= 1'b1;
         s_reg.rst_n <= 1'b1;
         s_reg.rby1 <= 1'b1;
         s_reg.rby2 <= 1'b1;
      end
      else
         s_reg <= s_next;
   end
   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   always_comb
   begin
      case (paddr)
         REG_ADDR: prdata = 32'(s_reg.addr);
         REG_DATA: prdata = 32'(s_reg.wdat);
         REG_RDAT: prdata = 32'(s_reg.rdat);
         REG_STAT: prdata = 32'({s_reg.rby2, s_reg.tmo, s_reg.fail,
                                 s_reg.done, s_reg.st != S_IDLE});
         default: prdata = 32'h0000_0000;
      endcase
   end
   assign flash_addr = s_reg.addr;
   assign flash_dq_out = s_reg.wdat;
   assign flash_dq_oe = s_reg.dq_oe;
   assign flash_ce_n = s_reg.ce_n;
   assign flash_oe_n = s_reg.oe_n;
   assign flash_we_n = s_reg.we_n;
   assign flash_reset_n = s_reg.rst_n;
   assign flash_reset_hv = s_reg.hv;
   assign protect_accel_input = s_reg.acc;
   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   chk_reset_hold: assert property ($rose(flash_reset_n) |->
      flash_oe_n [*3])
      else $error("read started too soon after reset");
   chk_strobe_excl: assert property (flash_we_n || flash_oe_n)
      else $error("write and read strobes together");
   chk_fail_reset: assert property ($rose(s_reg.fail) |->
      !flash_reset_n)
      else $error("timeout without device reset");
   chk_hv_nowrite: assert property (s_reg.st == S_HV_SET |->
      flash_we_n)
      else $error("write during elevated reset setup");
   sequence wr_strobe_low;
      !flash_we_n [*4];
   endsequence
   chk_write_pulse: assert property ($fell(flash_we_n) |->
      wr_strobe_low ##1 flash_we_n)
      else $error("write strobe not four cycles long");
   chk_reset_pulse: assert property ($fell(flash_reset_n) |->
      !flash_reset_n [*8])
      else $error("device reset pulse too short");
endmodule : fleo_host

// File: tb/fleo_flash_model.sv
`timescale 1ns/1ns
module fleo_flash_model
   import fleo_pkg::*;
(
   // bench controls
   input wire logic clk,
   input wire logic stall,
   input wire logic [15:0] dur,
   // flash pins
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] din,
   output logic [DATA_W-1:0] dout,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic rst_n,
   input wire logic accel,
   output logic rb_n
);
   logic [15:0] mem [256];
   logic [15:0] pd, wd, last = 16'h0000, val;
   logic [ADDR_W-1:0] wa, pa = '0;
   logic busy = 0, armed = 0, erase = 0, tog = 0, tmo = 0;
   logic was_we = 1, was_rd = 0, stby = 0, acc_seen = 0;
   int cnt = 0, lo_cnt = 0;
   wire rd = !ce_n && !oe_n && we_n;
   initial for (int i = 0; i < 256; i++) mem[i] = 16'hffff;
   assign rb_n = !busy;
   // status only from the busy bank; no suspend, so bit 2 stays still
   assign val = (busy && addr[21:20] == pa[21:20]) ?
      {8'h00, !erase && !pd[7], tog, tmo, 5'h00} : mem[addr[7:0]];
   // a released bus must not keep showing the last word
   assign dout = rd ? val : ~last;
   always @(posedge clk)
   begin
      was_we <= we_n | ce_n;
      was_rd <= rd;
      if (rd) last <= val;
      if (!(we_n | ce_n)) wa <= addr;
      if (!(we_n | ce_n)) wd <= din;
      if (!rst_n)
      begin
         busy <= 0;
         armed <= 0;
         lo_cnt <= lo_cnt + 1;
         if (lo_cnt == 0) stby <= 0;
         if (lo_cnt >= RPD_CYC - 1) stby <= 1;
      end
      else
      begin
         lo_cnt <= 0;
         if (!was_we && (we_n | ce_n) && !busy)
         begin
            armed <= wd == 16'h00a0;
            if (armed || wd == 16'h0030 || wd == 16'h0010)
            begin
               busy <= 1;
               cnt <= 0;
               tmo <= 0;
               pa <= wa;
               pd <= wd;
               erase <= !armed;
               if (!armed) mem[wa[7:0]] <= 16'h0000;
            end
         end
         if (busy)
         begin
            // accelerated runs take two thirds of the time
            cnt <= cnt + (accel ? 3 : 2);
            acc_seen <= acc_seen | accel;
            if (stall && cnt >= dur) tmo <= 1;
            if (!stall && cnt >= dur * 2)
            begin
               busy <= 0;
               mem[pa[7:0]] <= erase ? 16'hffff : mem[pa[7:0]] & pd;
            end
            if (rd && !was_rd) tog <= !tog;
         end
      end
   end
endmodule : fleo_flash_model

// File: tb/fleo_host_bench.sv
`timescale 1ns/1ns
module fleo_host_bench;
   import fleo_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, dq_oe, ce_n, oe_n, we_n, rst_n, hv, acc, rb_n;
   logic stall = 0, t1;
   logic [15:0] dur = 16'h07d0;
   logic [ADDR_W-1:0] fa;
   logic [DATA_W-1:0] dq_out, dq_in, mdq;
   int error_cnt = 0, total_checks = 0;
   always #10 pclk = ~pclk;
   assign dq_in = dq_oe ? dq_out : mdq;
   fleo_host fleo_host_i(.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .flash_addr(fa), .flash_dq_in(dq_in), .flash_dq_out(dq_out),
      .flash_dq_oe(dq_oe), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
      .flash_we_n(we_n), .flash_reset_n(rst_n), .flash_reset_hv(hv),
      .protect_accel_input(acc), .ready_busy_out_n(rb_n));
   fleo_flash_model fleo_flash_model_i(.clk(pclk), .stall(stall),
      .dur(dur), .addr(fa), .din(dq_in), .dout(mdq), .ce_n(ce_n),
      .oe_n(oe_n), .we_n(we_n), .rst_n(rst_n), .accel(acc), .rb_n(rb_n));
   // ---------------------------------------------------------------
   // bus tasks
   // ---------------------------------------------------------------
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   // bounded poll; a stuck busy bit counts as a mismatch
   task idle;
      int n;
      n = 0;
      do
      begin
         apb(1'b0, REG_STAT, 32'h0);
         n++;
      end
      while (q[ST_BUSY] !== 1'b0 && n < 4000);
      if (n >= 4000) check(q, 32'h0);
   endtask : idle
   task cmd(input logic [31:0] c);
      apb(1'b1, REG_CTRL, c);
      idle();
   endtask : cmd
   task setw(input logic [21:0] a, input logic [15:0] d);
      apb(1'b1, REG_ADDR, {10'h000, a});
      apb(1'b1, REG_DATA, {16'h0000, d});
   endtask : setw
   task rd(input logic [21:0] a);
      apb(1'b1, REG_ADDR, {10'h000, a});
      cmd(32'h1);
      apb(1'b0, REG_RDAT, 32'h0);
   endtask : rd
   task tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial
   begin
      repeat (90000) @(posedge pclk);
      error_cnt++;
      tally_and_finish();
   end
   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, REG_STAT, 32'h0);
      check(q & 32'h11, 32'h10);
      check({pready, pslverr}, 2'b10);
      rd(22'h000010);
      check(q, 32'hffff);
      setw(22'h000010, 16'h00a0);
      cmd(32'h2);
      apb(1'b1, REG_DATA, 32'h1234);
      cmd(32'h2);
      rd(22'h000010);
      check(q[7], 1'b1);
      t1 = q[6];
      rd(22'h000010);
      check(q[6], !t1);
      rd(22'h300010);
      check(q, 32'hffff);
      apb(1'b1, REG_CTRL, 32'h4);
      apb(1'b0, REG_STAT, 32'h0);
      check(q[ST_BUSY], 1'b1);
      idle();
      check(q[2:1], 2'b01);
      rd(22'h000010);
      check(q, 32'h1234);
      $display("program test done");
      dur <= 16'h003c;
      setw(22'h000011, 16'h00a0);
      cmd(32'h2);
      apb(1'b1, REG_DATA, 32'h00f0);
      cmd(32'h2);
      cmd(32'h144);
      check(q[2:1], 2'b01);
      check(fleo_flash_model_i.acc_seen, 1'b1);
      rd(22'h000011);
      check(q, 32'h00f0);
      for (int op = 1; op < 3; op++)
      begin
         setw(22'h000010, op == 1 ? 16'h0030 : 16'h0010);
         cmd(32'h2);
         check(fleo_flash_model_i.mem[8'h10], 32'h0);
         cmd(32'h4 | (op << CTRL_OP_LSB));
         check(q[2:1], 2'b01);
         rd(22'h000010);
         check(q, 32'hffff);
      end
      $display("erase test done");
      stall <= 1'b1;
      dur <= 16'h012c;
      setw(22'h000013, 16'h00a0);
      cmd(32'h2);
      apb(1'b1, REG_DATA, 32'h0055);
      cmd(32'h2);
      cmd(32'h4);
      check(q[3:2], 2'b11);
      cmd(32'h3);
      stall <= 1'b0;
      check(fleo_flash_model_i.stby, 1'b1);
      check(q[ST_RDY], 1'b1);
      rd(22'h000013);
      check(q, 32'hffff);
      $display("timeout test done");
      setw(22'h3fffff, 16'h0000);
      cmd(32'h5);
      check({fleo_flash_model_i.wa[6], fleo_flash_model_i.wa[1:0]},
         3'b010);
      setw(22'h000000, 16'h0000);
      cmd(32'h6);
      check({fleo_flash_model_i.wa[6], fleo_flash_model_i.wa[1:0]},
         3'b110);
      cmd(32'h80);
      check(hv, 1'b1);
      cmd(32'h0);
      check(hv, 1'b0);
      $display("protect test done");
      tally_and_finish();
   end
endmodule : fleo_host_bench
